// *** core/lde_top.v ***
// lane error status block: apb slave, link page, threshold, status pages
// assumes apb master on mclk; error pulses from the lane decoders
//
// Contract
// - eight-bit read-only invalid-code status, bit n is lane n
// - read-only stray control character status, bit n is lane n
// - status bit is one when lane count reaches the threshold
// - link page register selects which link's status is read
//
// Register access over APB is this design's own decision.
`include "lde_regs.vh"

module lde_top #(
   parameter LANES  = 8,
   parameter LINKS  = 2,
   parameter PAGE_W = 1,
   parameter ADDR_W = 16
) (
   input  wire                   mclk,
   input  wire                   rst,
   input  wire                   psel,
   input  wire                   penable,
   input  wire                   pwrite,
   input  wire [ADDR_W-1:0]      paddr,
   input  wire [31:0]            pwdata,
   output reg  [31:0]            prdata,
   output reg                    pready,
   output reg                    pslverr,
   input  wire [LINKS*LANES-1:0] invalid_code_err,
   input  wire [LINKS*LANES-1:0] stray_ctrl_err
);

   // ==================================================================
   // control registers
   reg  [PAGE_W-1:0]      link_page;
   reg  [7:0]             error_count_threshold;
   wire [LINKS*LANES-1:0] invalid_code_status;
   wire [LINKS*LANES-1:0] stray_ctrl_status;

   wire [11:0] idx    = paddr[13:2];
   wire        access = psel & penable & ~pready;
   wire        hit_page = (idx == `LDE_IDX_LINK_PAGE);
   wire        hit_thr  = (idx == `LDE_IDX_THRESHOLD);
   wire        hit_nit  = (idx == `LDE_IDX_INVALID_CODE);
   wire        hit_ctl  = (idx == `LDE_IDX_STRAY_CTRL);
   wire        mapped   = hit_page | hit_thr | hit_nit | hit_ctl;

   // ==================================================================
   // counter banks, one per link and error type
   genvar l;
   generate
      for (l = 0; l < LINKS; l = l + 1)
      begin : g_link
         lde_err_counter #(.LANES(LANES)) u_nit (
            .mclk                  (mclk),
            .rst                   (rst),
            .err                   (invalid_code_err[l*LANES +: LANES]),
            .error_count_threshold (error_count_threshold),
            .status                (invalid_code_status[l*LANES +: LANES])
         );
         lde_err_counter #(.LANES(LANES)) u_ctl (
            .mclk                  (mclk),
            .rst                   (rst),
            .err                   (stray_ctrl_err[l*LANES +: LANES]),
            .error_count_threshold (error_count_threshold),
            .status                (stray_ctrl_status[l*LANES +: LANES])
         );
      end
   endgenerate

   // ==================================================================
   // page selection; out-of-range pages read zero
   reg [LANES-1:0] page_nit;
   reg [LANES-1:0] page_ctl;
   integer k;
   always @*
   begin
      page_nit = {LANES{1'b0}};
      page_ctl = {LANES{1'b0}};
      for (k = 0; k < LINKS; k = k + 1)
      begin
         if (link_page == k[PAGE_W-1:0])
         begin
            page_nit = invalid_code_status[k*LANES +: LANES];
            page_ctl = stray_ctrl_status[k*LANES +: LANES];
         end
      end
   end

   // ==================================================================
   // read mux
   reg [31:0] next_prdata;
   always @*
   begin
      next_prdata = 32'h0000_0000;
      if (hit_page)
         next_prdata[PAGE_W-1:0] = link_page;
      else if (hit_thr)
         next_prdata[7:0] = error_count_threshold;
      else if (hit_nit)
         next_prdata[LANES-1:0] = page_nit;
      else if (hit_ctl)
         next_prdata[LANES-1:0] = page_ctl;
   end

   // ==================================================================
   // apb slave: answer one cycle into the access phase
   always @(posedge mclk)
   begin
      if (rst)
      begin
         // reset page is zero; sized to the page field, not the macro
         link_page             <= {PAGE_W{1'b0}};
         error_count_threshold <= `LDE_THRESHOLD_RST;
         prdata                <= 32'h0000_0000;
         pready                <= 1'b0;
         pslverr               <= 1'b0;
      end
      else
      begin
         pready  <= access;
         pslverr <= access & ~mapped;
         prdata  <= (access & ~pwrite) ? next_prdata : 32'h0000_0000;
         // status registers ignore writes; they only reflect counters
         if (access && pwrite && hit_page)
            link_page <= pwdata[`LDE_LINK_PAGE_LSB +: PAGE_W];
         if (access && pwrite && hit_thr)
            error_count_threshold <= pwdata[`LDE_THRESHOLD_LSB +: 8];
      end
   end

endmodule // lde_top

// *** core/lde_regs.vh ***
// register indices, field positions and reset values of the lane error block
// assumes word-indexed apb access: byte address = 4 * index
`ifndef LDE_REGS_VH
`define LDE_REGS_VH

// =====================================================================
// register indices (byte address is four times the index)
`define LDE_IDX_LINK_PAGE     12'h300
`define LDE_IDX_INVALID_CODE  12'h46e
`define LDE_IDX_STRAY_CTRL    12'h46f
`define LDE_IDX_THRESHOLD     12'h400

// =====================================================================
// fields and reset values
`define LDE_LINK_PAGE_LSB     0
`define LDE_THRESHOLD_LSB     0
`define LDE_LINK_PAGE_RST     8'h00
`define LDE_THRESHOLD_RST     8'h01
`define LDE_STATUS_RST        8'h00
`define LDE_COUNT_MAX         8'hff

`endif

// *** core/lde_err_counter.v ***
// per-lane saturating error counters and threshold status for one link
// assumes err inputs are one-cycle pulses synchronous to mclk
`include "lde_regs.vh"

module lde_err_counter #(
   parameter LANES = 8
) (
   input  wire             mclk,
   input  wire             rst,
   input  wire [LANES-1:0] err,
   input  wire [7:0]       error_count_threshold,
   output reg  [LANES-1:0] status
);

   // ==================================================================
   // one counter per lane
   genvar g;
   generate
      for (g = 0; g < LANES; g = g + 1)
      begin : g_lane
         reg [7:0] cnt;
         always @(posedge mclk)
         begin
            if (rst)
            begin
               cnt       <= 8'h00;
               status[g] <= 1'b0;
            end
            else
            begin
               // saturate so a long error burst never wraps back to pass
               if (err[g] && cnt != `LDE_COUNT_MAX)
                  cnt <= cnt + 8'h01;
               status[g] <= (cnt >= error_count_threshold);
            end
         end
      end
   endgenerate

endmodule // lde_err_counter

// *** sim/lde_props_properties.sv ***
// checker: apb answers of the lane error block
// assumes binding to lde_top on one mclk domain
module lde_props #(
   parameter ADDR_W = 16
) (
   input wire logic              mclk,
   input wire logic              rst,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr
);
   // ==========
   // properties
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   wire [11:0] idx = paddr[13:2];
   reset_quiet_a: assert property ($fell(rst) |-> !pready && prdata == 0)
      else $error("bus busy after reset");
   invalid_word_a: assert property (pready && idx == 12'h46e
      |-> prdata[31:8] == 0 && !pslverr) else $error("bad status word");
   stray_word_a: assert property (pready && idx == 12'h46f
      |-> prdata[31:8] == 0 && !pslverr) else $error("bad stray word");
   page_word_a: assert property (pready && idx == 12'h300
      |-> prdata[31:1] == 0 && !pslverr) else $error("bad page word");
   limit_word_a: assert property (pready && idx == 12'h400
      |-> prdata[31:8] == 0 && !pslverr) else $error("bad limit word");
endmodule // lde_props
bind lde_top lde_props #(.ADDR_W(ADDR_W)) u_lde_props (.mclk(mclk),
   .rst(rst), .paddr(paddr), .prdata(prdata), .pready(pready),
   .pslverr(pslverr));

// *** sim/lde_link_tx.sv ***
// far-side transmitter model: one-cycle lane error pulses
// assumes pulses launched right after a rising mclk edge
module lde_link_tx;
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] invalid_code_err = 0;
   logic [15:0] stray_ctrl_err = 0;
   task pulse(input bit k, input int b, input int gap);
      repeat (gap) @(posedge testbench.mclk);
      if (k) invalid_code_err[b] <= 1'b1;
      else stray_ctrl_err[b] <= 1'b1;
      @(posedge testbench.mclk);
      invalid_code_err <= 0;
      stray_ctrl_err <= 0;
   endtask
endmodule // lde_link_tx

// *** sim/testbench.sv ***
// bench: random lane errors, paged status reads over apb
// assumes pready within 20 negedges of the access phase, checked by a bounded wait
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
   logic [15:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, r;
   logic pready, pslverr, e;
   int fails, n_checks, seed = 28855, cnt[2][16], th = 1, p, b, k;
   lde_link_tx u_lde_link_tx();
   lde_top u_lde_top (.mclk(mclk), .rst(rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .invalid_code_err(u_lde_link_tx.invalid_code_err),
      .stray_ctrl_err(u_lde_link_tx.stray_ctrl_err));
   initial forever #2 mclk = ~mclk;
   // ==========
   // tasks
   task wrap_up;
      if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input [31:0] g, input [31:0] x);
      n_checks++;
      if (g !== x)
      begin
         fails++;
         $display("Error %0t got %h exp %h", $time, g, x);
      end
   endtask
   task apb(input bit w, input [11:0] i, input [31:0] d);
      int n;
      @(posedge mclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, 2'b00, i, 2'b00, d};
      @(posedge mclk);
      penable <= 1;
      n = 0;
      // look half a cycle before the edge so the answer's own edge
      // cannot race the design's update of pready and prdata
      do
      begin
         @(negedge mclk);
         n++;
      end
      while (pready !== 1 && n < 20);
      if (pready !== 1)
      begin
         fails++;
         wrap_up;
      end
      r = prdata;
      e = pslverr;
      @(posedge mclk);
      {psel, penable} <= 2'b00;
   endtask
   // error count at or above limit sets the lane bit
   function [31:0] st(int k, int p);
      st = 0;
      for (int n = 0; n < 8; n++) st[n] = cnt[k][p * 8 + n] >= th;
   endfunction
   // ==========
   // main sequence
   initial
   begin
      repeat (8) @(posedge mclk);
      rst <= 0;
      apb(0, 12'h400, 0); chk(r, 1);
      apb(0, 12'h46e, 0); chk(r, 0);
      apb(0, 12'h46f, 0); chk(r, 0);
      repeat (60)
      begin
         b = {$random(seed)} % 16;
         k = {$random(seed)} % 2;
         u_lde_link_tx.pulse(k, b, {$random(seed)} % 3);
         cnt[k][b]++;
         if ({$random(seed)} % 6 == 0)
         begin
            th = {$random(seed)} % 5;
            apb(1, 12'h400, th);
         end
         p = {$random(seed)} % 2;
         apb(1, 12'h300, p);
         apb(0, 12'h46e, 0); chk(r, st(1, p));
         apb(1, 12'h46f, 32'hffff_ffff);
         apb(0, 12'h46f, 0); chk(r, st(0, p));
      end
      apb(0, 12'h123, 0); chk(e, 1);
      wrap_up;
   end
endmodule // testbench
